// >>> adrs_defs.svh
// Offsets, field positions, reset values and timing counts of the converter control block
// Notes on behaviour
// R1: Result readable in two bytes after conversion
// R2: Single-ended code is Vin*1024/Vref, unsigned
// R3: Single-ended 0x000 is ground, 0x3ff full
// R4: Differential code is diff*gain*512/Vref
// R5: Differential result in ten-bit two's complement
// R6: Sign bit lands in the high byte
// R7: Left adjust bit picks result justification
// R8: Select register: reference 7:6, adjust 5, input 4:0
// R9: Reference change waits for conversion end
// R10: Reference codes: external, supply, reserved, internal
// R11: No internal reference with external drive
// R12: Shared pins must not toggle mid-conversion
// R13: Toggle enable after sleep before differential
// R14: Same-pin differential reading gives offset
// R15: Left adjust change shows at once
// R16: Input change waits for conversion end
// R17: First conversion 25 cycles, later 13
// R18: Done flag set once result updated
// R19: Active selection loaded at start or completion
// R20: Left adjust: 9:2 high, 1:0 low top
`ifndef ADRS_DEFS_SVH
`define ADRS_DEFS_SVH

`define ADRS_ADDR_SEL 5'h00
`define ADRS_ADDR_CTRL 5'h04
`define ADRS_ADDR_RES_LO 5'h08
`define ADRS_ADDR_RES_HI 5'h0c
`define ADRS_ADDR_ACTIVE 5'h10

`define ADRS_SEL_RESET 8'h00
`define ADRS_SEL_REF_HI 7
`define ADRS_SEL_REF_LO 6
`define ADRS_SEL_LADJ 5
`define ADRS_SEL_IN_HI 4

`define ADRS_CTRL_EN 7
`define ADRS_CTRL_START 6
`define ADRS_CTRL_FLAG 4

`define ADRS_REF_EXT 2'h0
`define ADRS_REF_SUPPLY 2'h1
`define ADRS_REF_RSVD 2'h2
`define ADRS_REF_INT 2'h3

`define ADRS_DIFF_FIRST 5'h08
`define ADRS_DIFF_LAST 5'h1d
`define ADRS_DIFF_FLIP 10'h200

`define ADRS_CYC_FIRST 5'h19
`define ADRS_CYC_NORMAL 5'h0d
`define ADRS_TRIAL_FIRST 5'h0a

`define ADRS_RESP_OKAY 2'h0
`define ADRS_RESP_SLVERR 2'h2

`endif

// >>> adrs_pkg.sv
// Types shared by the converter control block
package adrs_pkg;
    typedef enum logic {
        ADRS_SAR_IDLE = 1'b0,
        ADRS_SAR_RUN = 1'b1
    } adrs_sar_state_e;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [4:0] input_sel;
    } adrs_sel_s;
endpackage

// >>> adrs_sar.sv
// Successive approximation sequencer for the ten-bit converter
`timescale 1ns/1ps
`include "adrs_defs.svh"
module adrs_sar (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic abort_in,
    input wire logic long_in,
    input wire logic cmp_in,
    output logic [9:0] dac_code_out,
    output logic sample_out,
    output logic busy_out,
    output logic done_out
);
    adrs_pkg::adrs_sar_state_e state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [9:0] code_r, code_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic trial_r, trial_nxt;
    logic sample_r, sample_nxt;
    logic done_r, done_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        code_nxt = code_r;
        bit_nxt = bit_r;
        trial_nxt = 1'b0;
        sample_nxt = 1'b0;
        done_nxt = 1'b0;
        case (state_r)
            adrs_pkg::ADRS_SAR_IDLE: begin
                if (start_in && !abort_in) begin
                    state_nxt = adrs_pkg::ADRS_SAR_RUN;
                    // Whole conversion spans the count down to zero [R17]
                    cnt_nxt = (long_in ? `ADRS_CYC_FIRST : `ADRS_CYC_NORMAL) - 5'h01;
                    code_nxt = 10'h000;
                    sample_nxt = 1'b1;
                end
            end
            adrs_pkg::ADRS_SAR_RUN: begin
                if (trial_r && !cmp_in) begin
                    code_nxt[bit_r] = 1'b0;
                end
                if (cnt_r > `ADRS_TRIAL_FIRST) begin
                    sample_nxt = 1'b1;
                end else if (cnt_r != 5'h00) begin
                    bit_nxt = 4'(cnt_r - 5'h01);
                    code_nxt[4'(cnt_r - 5'h01)] = 1'b1;
                    trial_nxt = 1'b1;
                end
                if (abort_in) begin
                    state_nxt = adrs_pkg::ADRS_SAR_IDLE;
                    trial_nxt = 1'b0;
                    sample_nxt = 1'b0;
                end else if (cnt_r == 5'h00) begin
                    state_nxt = adrs_pkg::ADRS_SAR_IDLE;
                    done_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            default: begin
                state_nxt = adrs_pkg::ADRS_SAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r <= adrs_pkg::ADRS_SAR_IDLE;
            cnt_r <= 5'h00;
            code_r <= 10'h000;
            bit_r <= 4'h0;
            trial_r <= 1'b0;
            sample_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            code_r <= code_nxt;
            bit_r <= bit_nxt;
            trial_r <= trial_nxt;
            sample_r <= sample_nxt;
            done_r <= done_nxt;
        end
    end

    assign dac_code_out = code_r;
    assign sample_out = sample_r;
    assign busy_out = (state_r == adrs_pkg::ADRS_SAR_RUN);
    assign done_out = done_r;
endmodule

// >>> adrs_top.sv
// Converter control, result formatting and AXI4-Lite register slave
`timescale 1ns/1ps
`include "adrs_defs.svh"
module adrs_top (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_in,
    output logic [9:0] dac_code_out,
    output logic sample_out,
    output logic [1:0] reference_select_out,
    output logic internal_reference_on_out,
    output logic [4:0] input_select_out
);
    // Input codes in this window are differential pairs
    function automatic logic is_diff(input logic [4:0] sel);
        is_diff = (sel >= `ADRS_DIFF_FIRST) && (sel <= `ADRS_DIFF_LAST);
    endfunction

    function automatic logic [4:0] word_addr(input logic [31:0] addr);
        word_addr = {addr[4:2], 2'b00};
    endfunction

    // Register contents and conversion control state
    logic [7:0] sel_reg_r, sel_reg_nxt;
    logic enable_r, enable_nxt;
    logic first_r, first_nxt;
    logic flag_r, flag_nxt;
    logic [9:0] result_r, result_nxt;
    adrs_pkg::adrs_sel_s active_r, active_nxt;
    logic int_ref_r, int_ref_nxt;
    logic start_r, start_nxt;
    logic long_r, long_nxt;

    // Bus state
    logic aw_got_r, aw_got_nxt;
    logic [4:0] aw_addr_r, aw_addr_nxt;
    logic w_got_r, w_got_nxt;
    logic [7:0] w_data_r, w_data_nxt;
    logic w_lane_r, w_lane_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic arready_r, arready_nxt;

    logic sar_busy;
    logic sar_done;
    logic wr_fire;
    logic busy_view;
    logic [7:0] res_lo;
    logic [7:0] res_hi;

    adrs_sar u_sar (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .start_in(start_r),
        .abort_in(!enable_r),
        .long_in(long_r),
        .cmp_in(comparator_in),
        .dac_code_out(dac_code_out),
        .sample_out(sample_out),
        .busy_out(sar_busy),
        .done_out(sar_done)
    );

    // Pending start counts as busy so a second start before the run begins is ignored
    assign busy_view = sar_busy || start_r;

    // Byte view follows the live adjust bit, not the one at conversion [R15]
    always_comb begin
        if (sel_reg_r[`ADRS_SEL_LADJ]) begin
            res_hi = result_r[9:2]; // [R20] [R7] [R6]
            res_lo = {result_r[1:0], 6'h00}; // [R20]
        end else begin
            res_hi = {6'h00, result_r[9:8]}; // [R7] [R6]
            res_lo = result_r[7:0]; // [R20]
        end
    end

    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

    // Write channel: address and data taken in either order
    always_comb begin
        aw_got_nxt = aw_got_r;
        aw_addr_nxt = aw_addr_r;
        w_got_nxt = w_got_r;
        w_data_nxt = w_data_r;
        w_lane_nxt = w_lane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && !aw_got_r && !bvalid_r) begin
            aw_got_nxt = 1'b1;
            aw_addr_nxt = word_addr(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_got_r && !bvalid_r) begin
            w_got_nxt = 1'b1;
            w_data_nxt = s_axi_wdata[7:0];
            w_lane_nxt = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_addr_r == `ADRS_ADDR_SEL || aw_addr_r == `ADRS_ADDR_CTRL) ?
                `ADRS_RESP_OKAY : `ADRS_RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    // Register effects and conversion control
    always_comb begin
        sel_reg_nxt = sel_reg_r;
        enable_nxt = enable_r;
        first_nxt = first_r;
        flag_nxt = flag_r;
        result_nxt = result_r;
        active_nxt = active_r;
        start_nxt = 1'b0;
        long_nxt = long_r;
        if (wr_fire && w_lane_r && aw_addr_r == `ADRS_ADDR_SEL) begin
            // Fields land here; the converter only sees the active copy [R8]
            sel_reg_nxt = w_data_r;
        end
        if (wr_fire && w_lane_r && aw_addr_r == `ADRS_ADDR_CTRL) begin
            enable_nxt = w_data_r[`ADRS_CTRL_EN];
            if (w_data_r[`ADRS_CTRL_EN] && !enable_r) begin
                first_nxt = 1'b1; // [R17]
            end
            if (w_data_r[`ADRS_CTRL_FLAG]) begin
                flag_nxt = 1'b0;
            end
            if (w_data_r[`ADRS_CTRL_START] && w_data_r[`ADRS_CTRL_EN] && !busy_view) begin
                start_nxt = 1'b1;
                // Enabling in the same write still gets the long conversion [R17]
                long_nxt = first_r || !enable_r;
                first_nxt = 1'b0;
                active_nxt.ref_sel = sel_reg_r[`ADRS_SEL_REF_HI:`ADRS_SEL_REF_LO]; // [R19]
                active_nxt.input_sel = sel_reg_r[`ADRS_SEL_IN_HI:0]; // [R19]
            end
        end
        if (sar_done && enable_r) begin
            // Sign bit of the offset code is flipped for two's complement [R5] [R4]
            if (is_diff(active_r.input_sel)) begin
                result_nxt = dac_code_out ^ `ADRS_DIFF_FLIP; // [R5] [R4]
            end else begin
                result_nxt = dac_code_out; // [R2] [R3]
            end
            // Set wins over a clear in the same cycle [R18]
            flag_nxt = 1'b1; // [R18] [R1]
            // Held selections take effect only now [R9] [R16] [R19]
            active_nxt.ref_sel = sel_reg_nxt[`ADRS_SEL_REF_HI:`ADRS_SEL_REF_LO];
            active_nxt.input_sel = sel_reg_nxt[`ADRS_SEL_IN_HI:0];
        end
    end

    // Only the internal option powers the on-chip reference [R10]
    assign int_ref_nxt = (active_nxt.ref_sel == `ADRS_REF_INT);

    // Read channel
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `ADRS_RESP_OKAY;
            case (word_addr(s_axi_araddr))
                `ADRS_ADDR_SEL: begin
                    rdata_nxt = {24'h000000, sel_reg_r};
                end
                `ADRS_ADDR_CTRL: begin
                    rdata_nxt = {24'h000000, enable_r, busy_view, 1'b0, flag_r, 4'h0};
                end
                `ADRS_ADDR_RES_LO: begin
                    rdata_nxt = {24'h000000, res_lo}; // [R1]
                end
                `ADRS_ADDR_RES_HI: begin
                    rdata_nxt = {24'h000000, res_hi}; // [R1]
                end
                `ADRS_ADDR_ACTIVE: begin
                    rdata_nxt = {24'h000000, 1'b0, active_r};
                end
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `ADRS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sel_reg_r <= `ADRS_SEL_RESET;
            enable_r <= 1'b0;
            first_r <= 1'b0;
            flag_r <= 1'b0;
            result_r <= 10'h000;
            active_r <= '0;
            int_ref_r <= 1'b0;
            start_r <= 1'b0;
            long_r <= 1'b0;
        end else begin
            sel_reg_r <= sel_reg_nxt;
            enable_r <= enable_nxt;
            first_r <= first_nxt;
            flag_r <= flag_nxt;
            result_r <= result_nxt;
            active_r <= active_nxt;
            int_ref_r <= int_ref_nxt;
            start_r <= start_nxt;
            long_r <= long_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            aw_got_r <= 1'b0;
            aw_addr_r <= 5'h00;
            w_got_r <= 1'b0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `ADRS_RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `ADRS_RESP_OKAY;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            arready_r <= 1'b1;
        end else begin
            aw_got_r <= aw_got_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_got_r <= w_got_nxt;
            w_data_r <= w_data_nxt;
            w_lane_r <= w_lane_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
        end
    end

    // Ready registered from the next holding state: same timing, clean flop output
    assign awready_nxt = !aw_got_nxt && !bvalid_nxt;
    assign wready_nxt = !w_got_nxt && !bvalid_nxt;
    assign arready_nxt = !rvalid_nxt;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Analog side sees only the active copy, never a mid-conversion edit [R9] [R16]
    assign reference_select_out = active_r.ref_sel;
    assign internal_reference_on_out = int_ref_r;
    assign input_select_out = active_r.input_sel;
endmodule

// >>> adrs_analog_model.sv
// Analog source and comparator standing behind the converter inputs
`timescale 1ns/1ps
module adrs_analog_model (
    input wire logic [9:0] dac_code_in,
    input wire logic [9:0] level_in,
    output logic comparator_out
);
    // Level is the input already scaled to reference and gain
    // Nothing drives the external reference pin, so internal options are safe
    assign comparator_out = (level_in >= dac_code_in);
endmodule

// >>> adrs_top_sva.sv
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module adrs_top_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_out,
    input wire logic [1:0] reference_select_out,
    input wire logic internal_reference_on_out,
    input wire logic [4:0] input_select_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_sample_run;
        sample_out [*3];
    endsequence
    property p_wr_resp;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
    property p_b_retire;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_retire: assert property (p_b_retire) else $error("write response repeated");
    property p_r_retire;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_retire: assert property (p_r_retire) else $error("read response repeated");
    property p_int_ref;
        internal_reference_on_out == (reference_select_out == 2'h3);
    endproperty
    a_int_ref: assert property (p_int_ref) else $error("internal reference wrong");
    // Selection may only move while no sample is being taken
    property p_sel_change;
        $changed(reference_select_out) || $changed(input_select_out) |-> !sample_out;
    endproperty
    a_sel_change: assert property (p_sel_change) else $error("selection moved");
    property p_sample_min;
        $rose(sample_out) |-> s_sample_run;
    endproperty
    a_sample_min: assert property (p_sample_min) else $error("sampling too short");
    property p_sample_max;
        $rose(sample_out) |-> ##[1:15] !sample_out;
    endproperty
    a_sample_max: assert property (p_sample_max) else $error("sampling too long");
    property p_trials;
        $fell(sample_out) |-> !sample_out [*8];
    endproperty
    a_trials: assert property (p_trials) else $error("trial phase cut short");
endmodule
bind adrs_top adrs_top_chk chk_u (
    .core_clk_in, .rst_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .sample_out, .reference_select_out, .internal_reference_on_out,
    .input_select_out
);

// >>> testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adrs_defs.svh"
module testbench;
    localparam logic [31:0] A_SEL = 32'(`ADRS_ADDR_SEL);
    localparam logic [31:0] A_CTRL = 32'(`ADRS_ADDR_CTRL);
    localparam logic [31:0] A_LO = 32'(`ADRS_ADDR_RES_LO);
    localparam logic [31:0] A_HI = 32'(`ADRS_ADDR_RES_HI);
    localparam logic [31:0] ERR = 32'(`ADRS_RESP_SLVERR);
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [9:0] level = 10'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, cmp, sample, iref;
    logic [1:0] bresp, rresp, refsel, rs;
    logic [31:0] rdata, rv;
    logic [9:0] dac;
    logic [4:0] insel;
    int bad_count = 0;
    int num_checks = 0;
    int scnt = 0;
    int sbase = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (sample) scnt <= scnt + 1;
    adrs_top dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comparator_in(cmp), .dac_code_out(dac),
        .sample_out(sample), .reference_select_out(refsel),
        .internal_reference_on_out(iref), .input_select_out(insel)
    );
    adrs_analog_model model_u (.dac_code_in(dac), .level_in(level), .comparator_out(cmp));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 64) begin
            bad_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 64);
        rs = bresp;
        bready <= 1'b0;
        hang(n);
    endtask
    task automatic rd(input logic [31:0] a);
        int n;
        @(posedge core_clk_in);
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 64);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        hang(n);
    endtask
    // Level changes only between conversions, as a settled source would
    task automatic conv(input logic [7:0] sel, input logic [9:0] lv);
        level <= lv;
        wr(A_SEL, {24'h0, sel});
        sbase = scnt;
        wr(A_CTRL, 32'hc0);
    endtask
    task automatic finish_conv();
        int n;
        n = 0;
        do begin
            rd(A_CTRL);
            n++;
        end while (rv[`ADRS_CTRL_FLAG] !== 1'b1 && n < 64);
        hang(n);
        wr(A_CTRL, 32'h90);
    endtask
    task automatic res(input logic [9:0] c, input logic la);
        rd(A_LO);
        chk("low byte", rv, la ? {24'h0, c[1:0], 6'h0} : {24'h0, c[7:0]});
        rd(A_HI);
        chk("high byte", rv, la ? {24'h0, c[9:2]} : {30'h0, c[9:8]});
    endtask
    initial begin
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(A_SEL);
        chk("select reset", rv, 32'h0);
        rd(32'h14);
        chk("unmapped read", {30'h0, rs}, ERR);
        wr(A_LO, 32'h0);
        chk("result write", {30'h0, rs}, ERR);
        wr(A_SEL, 32'hff);
        rd(A_SEL);
        chk("select fields", rv, 32'hff);
        wstrb <= 4'h0;
        wr(A_SEL, 32'h00);
        chk("masked resp", {30'h0, rs}, 32'h0);
        wstrb <= 4'hf;
        rd(A_SEL);
        chk("masked write", rv, 32'hff);
        conv(8'h02, 10'h3ff);
        finish_conv();
        res(10'h3ff, 1'b0);
        chk("long sample", 32'(scnt - sbase), 32'd15);
        conv(8'h02, 10'h000);
        finish_conv();
        res(10'h000, 1'b0);
        chk("short sample", 32'(scnt - sbase), 32'd3);
        conv(8'h22, 10'h2a5);
        finish_conv();
        res(10'h2a5, 1'b1);
        conv(8'hed, 10'h070);
        finish_conv();
        res(10'h270, 1'b1);
        wr(A_SEL, 32'hcd);
        res(10'h270, 1'b0);
        conv(8'h02, 10'h3ff);
        wr(A_CTRL, 32'h00);
        rd(A_CTRL);
        chk("aborted", rv, 32'h0);
        res(10'h270, 1'b0);
        conv(8'hcd, 10'h3ff);
        finish_conv();
        chk("re-enable sample", 32'(scnt - sbase), 32'd15);
        res(10'h1ff, 1'b0);
        conv(8'hcd, 10'h000);
        finish_conv();
        res(10'h200, 1'b0);
        conv(8'h08, 10'h200);
        finish_conv();
        res(10'h000, 1'b0);
        conv(8'h42, 10'h155);
        wr(A_SEL, 32'hc3);
        chk("held reference", {30'h0, refsel}, 32'h1);
        chk("held input", {27'h0, insel}, 32'h2);
        finish_conv();
        chk("new reference", {30'h0, refsel}, 32'h3);
        chk("new input", {27'h0, insel}, 32'h3);
        res(10'h155, 1'b0);
        for (int i = 0; i < 4; i++) begin
            conv({i[1:0], 6'h02}, 10'h100);
            finish_conv();
            chk("reference code", {30'h0, refsel}, {30'h0, i[1:0]});
            chk("internal on", {31'h0, iref}, {31'h0, i == 3});
        end
        stop_test();
    end
endmodule
